// ==== hw/mcsp_map.vh ====
// register map, fields, reset values and timing counts of the main clock controller
`ifndef MCSP_MAP_VH
`define MCSP_MAP_VH
`define MCSP_ADDR_W          5
`define MCSP_OFF_CTRL        5'h00
`define MCSP_OFF_PRESC       5'h01
`define MCSP_OFF_FREEZE      5'h02
`define MCSP_OFF_STATE       5'h03
`define MCSP_OFF_FOSC_CTRL   5'h10
`define MCSP_OFF_FOSC_TRIM   5'h11
`define MCSP_OFF_FOSC_TEMP   5'h12
`define MCSP_OFF_ULP_CTRL    5'h18
`define MCSP_OFF_XOSC_CTRL   5'h1c
`define MCSP_RST_CTRL        8'h00
`define MCSP_RST_PRESC       8'h11
`define MCSP_RST_OSC_CTRL    8'h00
`define MCSP_BIT_SYSTEM_CLOCK_OUTPUT_ENABLE      7
`define MCSP_BIT_LOCK        0
`define MCSP_BIT_KEEP_RUNNING_STANDBY    1
`define MCSP_BIT_XENABLE     0
`define MCSP_BIT_XSEL        2
`define MCSP_BIT_FROZEN      7
`define MCSP_BIT_PEN         0
`define MCSP_BIT_EXT_CLOCK_STARTED        7
`define MCSP_BIT_XSTABLE     6
`define MCSP_BIT_USTABLE     5
`define MCSP_BIT_FSTABLE     4
`define MCSP_BIT_SWITCH      0
`define MCSP_MASK_CTRL       8'h83
`define MCSP_MASK_PRESC      8'h1f
`define MCSP_MASK_XOSC       8'h37
`define MCSP_MASK_XSETUP     8'h34
`define MCSP_SRC_FAST        2'h0
`define MCSP_SRC_ULP         2'h1
`define MCSP_SRC_XTAL        2'h2
`define MCSP_SRC_EXT         2'h3
`define MCSP_GATE_CYCLES     3'h4
`define MCSP_GUARD_WINDOW    3'h4
`define MCSP_GUARD_KEY       8'hd8
`endif

// ==== hw/mcsp_prescaler.v ====
// main clock prescaler producing a one-cycle peripheral clock enable
`timescale 1ns/1ps
module mcsp_prescaler (
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire       tick_i,
  input  wire       enable_i,
  input  wire [3:0] divider_i,
  output wire       per_tick_o
);
  reg [5:0] count_reg;
  reg [5:0] count_next;
  reg [5:0] limit;

  // division code to terminal count
  always @*
  begin
    case (divider_i)
      4'h0:    limit = 6'd1;
      4'h1:    limit = 6'd3;
      4'h2:    limit = 6'd7;
      4'h3:    limit = 6'd15;
      4'h4:    limit = 6'd31;
      4'h5:    limit = 6'd63;
      4'h8:    limit = 6'd5;
      4'h9:    limit = 6'd9;
      4'ha:    limit = 6'd11;
      4'hb:    limit = 6'd23;
      4'hc:    limit = 6'd47;
      default: limit = 6'd1;
    endcase
  end

  // running divider, new code takes effect at once
  always @*
  begin
    count_next = count_reg;
    if (tick_i)
    begin
      if (count_reg >= limit)
        count_next = 6'd0;
      else
        count_next = count_reg + 6'd1;
    end
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      count_reg <= 6'd0;
    else
      count_reg <= count_next;
  end

  assign per_tick_o = enable_i ? (tick_i && count_reg >= limit) : tick_i;
endmodule

// ==== hw/mcsp_top.v ====
// main clock source select, prescaler, lock and oscillator status registers
`timescale 1ns/1ps
`include "mcsp_map.vh"
module mcsp_top (
  input  wire       MCLK_I,
  input  wire       ARST_N_I,
  input  wire [4:0] ADDR_I,
  input  wire [7:0] WDATA_I,
  input  wire       WR_I,
  input  wire       RD_I,
  output reg  [7:0] RDATA_O,
  input  wire       INSTR_DONE_I,
  input  wire       FUSE_LOCK_I,
  input  wire       FUSE_FROZEN_I,
  input  wire [5:0] FUSE_TRIM_I,
  input  wire [3:0] FUSE_TEMP_I,
  input  wire       FAST_TICK_I,
  input  wire       ULP_TICK_I,
  input  wire       XTAL_TICK_I,
  input  wire       EXT_TICK_I,
  input  wire       XTAL_READY_I,
  input  wire       EXT_STARTED_I,
  input  wire       FAST_ANALOG_READY_I,
  input  wire [3:0] PERIPH_REQ_I,
  input  wire       SLEEP_I,
  input  wire       PERIPH_USES_SYSCLK_I,
  output wire       MAIN_TICK_O,
  output wire       PER_TICK_O,
  output wire       SYSTEM_CLOCK_OUTPUT_ENABLE_O,
  output wire       SYSTEM_CLOCK_OUTPUT_ENABLE_OE_O,
  output wire       FAST_OSC_POWER_O,
  output wire [5:0] FAST_TRIM_O,
  output wire [3:0] FAST_TEMP_O,
  output wire [1:0] MAIN_SOURCE_O
);
  reg  [7:0] ctrl_reg;
  reg  [7:0] presc_reg;
  reg        lock_reg;
  reg        lock_loaded_reg;
  reg  [7:0] fosc_ctrl_reg;
  reg  [7:0] ulp_ctrl_reg;
  reg  [7:0] xosc_ctrl_reg;
  reg  [5:0] trim_reg;
  reg  [3:0] temp_reg;
  reg        frozen_reg;
  reg  [2:0] guard_reg;
  reg  [1:0] active_src_reg;
  reg  [2:0] gate_cnt [0:3];
  reg  [7:0] rdata_next;
  wire [3:0] src_tick;
  wire [3:0] src_ready;
  wire [3:0] src_req;
  wire [3:0] src_keep;
  wire [3:0] src_open;
  wire       guard_open;
  wire       wr_ok;
  wire       key_write;
  wire       calib_locked;
  wire       xtal_busy;
  wire       switch_pending;
  wire       main_tick;

  assign src_tick  = {EXT_TICK_I, XTAL_TICK_I, ULP_TICK_I, FAST_TICK_I};
  assign src_ready = {EXT_STARTED_I, XTAL_READY_I && xosc_ctrl_reg[`MCSP_BIT_XENABLE], 1'b1,
                      FAST_ANALOG_READY_I || fosc_ctrl_reg[`MCSP_BIT_KEEP_RUNNING_STANDBY]};
  assign src_keep  = {1'b0, xosc_ctrl_reg[`MCSP_BIT_KEEP_RUNNING_STANDBY], ulp_ctrl_reg[`MCSP_BIT_KEEP_RUNNING_STANDBY],
                      fosc_ctrl_reg[`MCSP_BIT_KEEP_RUNNING_STANDBY]};

  // source requested by main select, by a peripheral or as the active source
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gen_src
      assign src_req[g]  = PERIPH_REQ_I[g] || (ctrl_reg[1:0] == g) || (active_src_reg == g);
      assign src_open[g] = (gate_cnt[g] == `MCSP_GATE_CYCLES);
      // gate opens after four oscillator cycles once requested and ready
      always @(posedge MCLK_I or negedge ARST_N_I)
      begin
        if (!ARST_N_I)
          gate_cnt[g] <= 3'd0;
        else if (!src_req[g])
          gate_cnt[g] <= 3'd0;
        else if (src_ready[g] && src_tick[g] && !src_open[g])
          gate_cnt[g] <= gate_cnt[g] + 3'd1;
      end
    end
  endgenerate

  assign FAST_OSC_POWER_O = src_req[0] || src_keep[0];

  // protection window after key write
  assign key_write  = WR_I && (ADDR_I == 5'h1f) && (WDATA_I == `MCSP_GUARD_KEY);
  assign guard_open = (guard_reg != 3'd0);
  assign wr_ok      = WR_I && guard_open;

  always @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      guard_reg <= 3'd0;
    else if (key_write)
      guard_reg <= `MCSP_GUARD_WINDOW;
    else if (wr_ok)
      guard_reg <= 3'd0;
    else if (guard_open && INSTR_DONE_I)
      guard_reg <= guard_reg - 3'd1;
  end

  assign calib_locked = frozen_reg || (lock_reg && ctrl_reg[1:0] == `MCSP_SRC_FAST);
  assign xtal_busy    = xosc_ctrl_reg[`MCSP_BIT_XENABLE] || src_open[2];

  // register writes
  always @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ctrl_reg        <= `MCSP_RST_CTRL;
      presc_reg       <= `MCSP_RST_PRESC;
      fosc_ctrl_reg   <= `MCSP_RST_OSC_CTRL;
      ulp_ctrl_reg    <= `MCSP_RST_OSC_CTRL;
      xosc_ctrl_reg   <= `MCSP_RST_OSC_CTRL;
      lock_reg        <= 1'b0;
      lock_loaded_reg <= 1'b0;
      trim_reg        <= 6'd0;
      temp_reg        <= 4'd0;
      frozen_reg      <= 1'b0;
    end
    else if (!lock_loaded_reg)
    begin
      lock_loaded_reg <= 1'b1;
      lock_reg        <= FUSE_LOCK_I;
      trim_reg        <= FUSE_TRIM_I;
      temp_reg        <= FUSE_TEMP_I;
      frozen_reg      <= FUSE_FROZEN_I;
    end
    else if (wr_ok)
    begin
      case (ADDR_I)
        `MCSP_OFF_CTRL:
          if (!lock_reg)
            ctrl_reg <= WDATA_I & `MCSP_MASK_CTRL;
        `MCSP_OFF_PRESC:
          if (!lock_reg)
            presc_reg <= WDATA_I & `MCSP_MASK_PRESC;
        `MCSP_OFF_FREEZE:
          if (!lock_reg && WDATA_I[`MCSP_BIT_LOCK])
            lock_reg <= 1'b1;
        `MCSP_OFF_FOSC_CTRL:
          fosc_ctrl_reg <= {6'd0, WDATA_I[`MCSP_BIT_KEEP_RUNNING_STANDBY], 1'b0};
        `MCSP_OFF_FOSC_TRIM:
          if (!calib_locked)
            trim_reg <= WDATA_I[5:0];
        `MCSP_OFF_FOSC_TEMP:
          if (!calib_locked)
            temp_reg <= WDATA_I[3:0];
        `MCSP_OFF_ULP_CTRL:
          ulp_ctrl_reg <= {6'd0, WDATA_I[`MCSP_BIT_KEEP_RUNNING_STANDBY], 1'b0};
        `MCSP_OFF_XOSC_CTRL:
          if (xtal_busy)
            xosc_ctrl_reg <= (xosc_ctrl_reg & `MCSP_MASK_XSETUP) | (WDATA_I & 8'h03);
          else
            xosc_ctrl_reg <= WDATA_I & `MCSP_MASK_XOSC;
        default:
          ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // switch to requested source once it is stable
  always @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      active_src_reg <= `MCSP_SRC_FAST;
    else if (ctrl_reg[1:0] != active_src_reg && src_open[ctrl_reg[1:0]])
      active_src_reg <= ctrl_reg[1:0];
  end

  assign switch_pending = (ctrl_reg[1:0] != active_src_reg);
  assign main_tick      = src_tick[active_src_reg] && src_open[active_src_reg];

  mcsp_prescaler u_presc (
    .clk_i      (MCLK_I),
    .arst_n_i   (ARST_N_I),
    .tick_i     (main_tick),
    .enable_i   (presc_reg[`MCSP_BIT_PEN]),
    .divider_i  (presc_reg[4:1]),
    .per_tick_o (PER_TICK_O)
  );

  assign MAIN_TICK_O   = main_tick;
  assign SYSTEM_CLOCK_OUTPUT_ENABLE_OE_O   = ctrl_reg[`MCSP_BIT_SYSTEM_CLOCK_OUTPUT_ENABLE];
  assign SYSTEM_CLOCK_OUTPUT_ENABLE_O      = ctrl_reg[`MCSP_BIT_SYSTEM_CLOCK_OUTPUT_ENABLE] && main_tick && (!SLEEP_I || PERIPH_USES_SYSCLK_I);
  assign FAST_TRIM_O   = trim_reg;
  assign FAST_TEMP_O   = temp_reg;
  assign MAIN_SOURCE_O = active_src_reg;

  // read mux, data one cycle after strobe
  always @*
  begin
    rdata_next = 8'h00;
    case (ADDR_I)
      `MCSP_OFF_CTRL:      rdata_next = ctrl_reg;
      `MCSP_OFF_PRESC:     rdata_next = presc_reg;
      `MCSP_OFF_FREEZE:    rdata_next = lock_reg ? 8'h00 : 8'h00;
      `MCSP_OFF_STATE:
      begin
        rdata_next[`MCSP_BIT_EXT_CLOCK_STARTED]    = EXT_STARTED_I;
        rdata_next[`MCSP_BIT_XSTABLE] = src_req[2] && src_open[2];
        rdata_next[`MCSP_BIT_USTABLE] = src_req[1] && src_open[1];
        rdata_next[`MCSP_BIT_FSTABLE] = src_req[0] && src_open[0];
        rdata_next[`MCSP_BIT_SWITCH]  = switch_pending;
      end
      `MCSP_OFF_FOSC_CTRL: rdata_next = fosc_ctrl_reg;
      `MCSP_OFF_FOSC_TRIM: rdata_next = {2'd0, trim_reg};
      `MCSP_OFF_FOSC_TEMP: rdata_next = {frozen_reg, 3'd0, temp_reg};
      `MCSP_OFF_ULP_CTRL:  rdata_next = ulp_ctrl_reg;
      `MCSP_OFF_XOSC_CTRL: rdata_next = xosc_ctrl_reg;
      default:             rdata_next = 8'h00;
    endcase
  end

  always @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      RDATA_O <= 8'h00;
    else if (RD_I)
      RDATA_O <= rdata_next;
    else
      RDATA_O <= 8'h00;
  end
endmodule

// ==== verif/mcsp_top_chk.sv ====
// port assertions for the main clock controller
`timescale 1ns/1ps
module mcsp_chk (
  input wire       MCLK_I,
  input wire       ARST_N_I,
  input wire [4:0] ADDR_I,
  input wire       WR_I,
  input wire       RD_I,
  input wire [7:0] RDATA_O,
  input wire       SLEEP_I,
  input wire       PERIPH_USES_SYSCLK_I,
  input wire       FAST_TICK_I,
  input wire       ULP_TICK_I,
  input wire       XTAL_TICK_I,
  input wire       EXT_TICK_I,
  input wire       MAIN_TICK_O,
  input wire       PER_TICK_O,
  input wire       SYSTEM_CLOCK_OUTPUT_ENABLE_O,
  input wire       SYSTEM_CLOCK_OUTPUT_ENABLE_OE_O,
  input wire [5:0] FAST_TRIM_O,
  input wire [3:0] FAST_TEMP_O,
  input wire [1:0] MAIN_SOURCE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  reg [1:0] age_reg;
  always @(posedge MCLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
      age_reg <= 2'h0;
    else if (age_reg != 2'h3)
      age_reg <= age_reg + 2'h1;
  property p_rd_idle; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  property p_lock_rd; $past(RD_I && ADDR_I == 5'h02) |-> RDATA_O == 8'h00; endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("lock register read not zero");
  property p_resv_rd;
    $past(RD_I && ADDR_I inside {[5'h04:5'h0f], [5'h13:5'h17], [5'h19:5'h1b]}) |-> RDATA_O == 8'h00;
  endproperty
  a_resv_rd: assert property (p_resv_rd) else $error("reserved address read not zero");
  property p_system_clock_output_enable_en; SYSTEM_CLOCK_OUTPUT_ENABLE_O |-> SYSTEM_CLOCK_OUTPUT_ENABLE_OE_O; endproperty
  a_system_clock_output_enable_en: assert property (p_system_clock_output_enable_en) else $error("clock out without enable");
  property p_sleep; SLEEP_I && !PERIPH_USES_SYSCLK_I |-> !SYSTEM_CLOCK_OUTPUT_ENABLE_O; endproperty
  a_sleep: assert property (p_sleep) else $error("clock out during sleep");
  property p_per_main; PER_TICK_O |-> MAIN_TICK_O; endproperty
  a_per_main: assert property (p_per_main) else $error("peripheral tick without main tick");
  property p_src;
    MAIN_TICK_O |-> (MAIN_SOURCE_O == 2'h0 ? FAST_TICK_I : MAIN_SOURCE_O == 2'h1 ? ULP_TICK_I :
                     MAIN_SOURCE_O == 2'h2 ? XTAL_TICK_I : EXT_TICK_I);
  endproperty
  a_src: assert property (p_src) else $error("main tick not from selected source");
  property p_trim; age_reg == 2'h3 && !$past(WR_I) |-> $stable(FAST_TRIM_O) && $stable(FAST_TEMP_O); endproperty
  a_trim: assert property (p_trim) else $error("calibration changed without write");
endmodule
bind mcsp_top mcsp_chk i_chk (.*);

// ==== verif/mcsp_top_tb_top.sv ====
// self-checking bench for the main clock controller
`timescale 1ns/1ps
`include "mcsp_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module mcsp_top_tb_top;
  reg        mclk = 1'b0;
  reg        arst_n = 1'b0;
  reg  [4:0] addr = 5'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg        rd_d = 1'b0;
  reg        idone = 1'b0;
  reg        f_lock = 1'b0;
  reg        f_frozen = 1'b0;
  reg  [5:0] f_trim = 6'h00;
  reg  [3:0] f_temp = 4'h0;
  reg  [3:0] ticks = 4'h0;
  reg        sleep = 1'b0;
  reg  [7:0] t;
  reg  [7:0] expq[$];
  wire [7:0] rdata;
  wire [5:0] trim;
  wire       main_tick;
  wire       per_tick;
  wire       system_clock_output_enable_oe;
  integer    seed = 32'he7c3;
  integer    fail_count = 0;
  integer    samples_checked = 0;
  integer    i;
  mcsp_top i_mcsp_top (.MCLK_I(mclk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .INSTR_DONE_I(idone), .FUSE_LOCK_I(f_lock), .FUSE_FROZEN_I(f_frozen), .FUSE_TRIM_I(f_trim),
    .FUSE_TEMP_I(f_temp), .FAST_TICK_I(ticks[0]), .ULP_TICK_I(ticks[1]), .XTAL_TICK_I(ticks[2]),
    .EXT_TICK_I(ticks[3]), .XTAL_READY_I(1'b1), .EXT_STARTED_I(1'b1), .FAST_ANALOG_READY_I(1'b1),
    .PERIPH_REQ_I(4'h0), .SLEEP_I(sleep), .PERIPH_USES_SYSCLK_I(1'b0), .MAIN_TICK_O(main_tick),
    .PER_TICK_O(per_tick), .SYSTEM_CLOCK_OUTPUT_ENABLE_O(), .SYSTEM_CLOCK_OUTPUT_ENABLE_OE_O(system_clock_output_enable_oe), .FAST_OSC_POWER_O(), .FAST_TRIM_O(trim),
    .FAST_TEMP_O(), .MAIN_SOURCE_O());
  always #20 mclk = ~mclk;
  always @(posedge mclk)
    ticks <= $random(seed);
  always @(posedge mclk)
    rd_d <= rd;
  always @(negedge mclk)
    if (rd_d)
      `CHK(rdata, expq.pop_front())
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task wr_reg(input [4:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  task pw(input [4:0] a, input [7:0] d);
    begin
      wr_reg(5'h1f, 8'hd8);
      wr_reg(a, d);
    end
  endtask
  task rd_reg(input [4:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      expq.push_back(e);
      @(posedge mclk);
      rd <= 1'b0;
    end
  endtask
  function integer dv(input integer c);
    dv = c < 6 ? 2 << c : c == 8 ? 6 : c == 9 ? 10 : 12 << (c - 10);
  endfunction
  task per_period(input integer want);
    integer n, m, k;
    begin
      n = 0;
      m = 0;
      for (k = 0; k < 3000 && n < 3; k++)
      begin
        @(negedge mclk);
        if (n == 2 && main_tick)
          m++;
        if (per_tick)
          n++;
      end
      if (n < 3)
      begin
        fail_count++;
        wrap_up;
      end
      `CHK(m, want)
    end
  endtask
  initial
  begin
    f_trim = $random(seed);
    f_temp = $random(seed);
    f_frozen = $random(seed);
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_reg(`MCSP_OFF_CTRL, `MCSP_RST_CTRL);
    rd_reg(`MCSP_OFF_PRESC, `MCSP_RST_PRESC);
    rd_reg(`MCSP_OFF_FOSC_CTRL, `MCSP_RST_OSC_CTRL);
    rd_reg(`MCSP_OFF_FOSC_TRIM, {2'h0, f_trim});
    rd_reg(`MCSP_OFF_FOSC_TEMP, {f_frozen, 3'h0, f_temp});
    rd_reg(5'h05, 8'h00);
    wr_reg(`MCSP_OFF_PRESC, 8'h03);
    rd_reg(`MCSP_OFF_PRESC, 8'h11);
    wr_reg(5'h1f, 8'hd8);
    repeat (4)
    begin
      @(posedge mclk);
      idone <= 1'b1;
      @(posedge mclk);
      idone <= 1'b0;
    end
    wr_reg(`MCSP_OFF_PRESC, 8'h03);
    rd_reg(`MCSP_OFF_PRESC, 8'h11);
    // divider codes 0 to 5 and 8 to 12 with the prescaler enabled, each period checked
    for (i = 0; i < 13; i++)
      if (i < 6 || i > 7)
      begin
        pw(`MCSP_OFF_PRESC, {3'h0, i[3:0], 1'b1});
        per_period(dv(i));
      end
    rd_reg(`MCSP_OFF_STATE, 8'h90);
    pw(`MCSP_OFF_PRESC, 8'h18);
    per_period(1);
    pw(`MCSP_OFF_CTRL, 8'hfc);
    rd_reg(`MCSP_OFF_CTRL, 8'h80);
    `CHK(system_clock_output_enable_oe, 1'b1)
    sleep <= 1'b1;
    repeat (20) @(posedge mclk);
    sleep <= 1'b0;
    t = f_frozen ? {2'h0, f_trim} : 8'h2a;
    pw(`MCSP_OFF_FOSC_TRIM, 8'h2a);
    rd_reg(`MCSP_OFF_FOSC_TRIM, t);
    pw(`MCSP_OFF_FREEZE, 8'h01);
    pw(`MCSP_OFF_PRESC, 8'h05);
    rd_reg(`MCSP_OFF_PRESC, 8'h18);
    pw(`MCSP_OFF_FOSC_TRIM, 8'h15);
    rd_reg(`MCSP_OFF_FOSC_TRIM, t);
    `CHK(trim, t[5:0])
    rd_reg(`MCSP_OFF_FREEZE, 8'h00);
    @(posedge mclk);
    arst_n <= 1'b0;
    f_lock <= 1'b1;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    pw(`MCSP_OFF_PRESC, 8'h05);
    rd_reg(`MCSP_OFF_PRESC, 8'h11);
    repeat (2) @(posedge mclk);
    wrap_up;
  end
endmodule
